// file: cie_exit_unit.sv
// Exit unit: executes subroutine and interrupt exits, owns pointer state.
`timescale 1ns/10ps

// How it works
// - Subroutine exit CC0D loads the pointer from the stack top on sign set, else adds one.
// - Exit 8C8D pops the stack top into the instruction pointer, stack pointer minus one.
// - Any taken interrupt exit sets the interrupt level state to binary 11, reopening acks.
// - Carry exit AC8D does a full interrupt exit on carry 1, else only steps the pointer.
// - Two carry forms exist, one taken on carry set and one taken only on carry clear.
// - Two zero forms exist, one taken on zero set and one taken only on zero clear.
// - The sign form does a full interrupt exit only on sign set, else falls through.
// - Other interrupt exits differ by top nibble: E no carry, 9 zero, D no zero, C sign.
module cie_exit_unit
  import cie_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                instrValid,
  input  wire logic [WORD_W-1:0]   instrWord,
  output logic                     instrReady,
  input  wire logic [WORD_W-1:0]   stackTopWord,
  input  wire logic                flagWrite,
  input  wire logic [FLAGS_W-1:0]  flagValue,
  input  wire logic                ipsWrite,
  input  wire logic [IPS_W-1:0]    ipsValue,
  output logic [WORD_W-1:0]        instruction_pointer,
  output logic [WORD_W-1:0]        stack_pointer,
  output logic [IPS_W-1:0]         interrupt_level_state,
  output logic [FLAGS_W-1:0]       statusFlags,
  output logic                     retireStrobe,
  output logic                     exitTaken,
  output logic                     unknownOp
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cie_state_e         state_q;
  cie_state_e         state_d;
  logic [WORD_W-1:0]  opWord_q;
  logic [WORD_W-1:0]  ip_q;
  logic [WORD_W-1:0]  ip_d;
  logic [WORD_W-1:0]  sp_q;
  logic [WORD_W-1:0]  sp_d;
  logic [IPS_W-1:0]   ips_q;
  logic [IPS_W-1:0]   ips_d;
  logic [FLAGS_W-1:0] flags_q;
  logic               ready_q;
  logic               retire_q;
  logic               taken_q;
  logic               unknown_q;
  logic               execNow;
  logic               takeExit;
  logic               takeIntExit;

  cie_dec_if decBus ();

  cie_exit_decoder u_dec (
    .dec (decBus.dec)
  );

  assign decBus.opWord = opWord_q;
  assign decBus.flags  = flags_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Two steps per opcode: the stack top is read from a synchronous
  // memory addressed by stack_pointer, so it is valid one cycle later.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (instrValid) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opWord_q <= 16'h0000;
    end else if (state_q == ST_IDLE && instrValid) begin
      opWord_q <= instrWord;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= (state_d == ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  always_comb begin
    execNow     = (state_q == ST_EXEC);
    takeExit    = execNow && decBus.isExit && decBus.condMet;
    takeIntExit = takeExit && decBus.isIntExit;
  end

  // Instruction pointer: pop on a taken exit, otherwise step by one
  always_comb begin
    ip_d = ip_q;
    if (takeExit) begin
      ip_d = stackTopWord;
    end else if (execNow) begin
      ip_d = ip_q + WORD_ONE;
    end
  end

  // Stack pointer: every taken exit is a pop
  always_comb begin
    sp_d = sp_q;
    if (takeExit) begin
      sp_d = sp_q - WORD_ONE;
    end
  end

  // Interrupt level: a taken interrupt exit wins over a same-cycle controller write so
  // that a finished handler always reopens acknowledgement.
  always_comb begin
    ips_d = ips_q;
    if (takeIntExit) begin
      ips_d = IPS_ACK_OK;
    end else if (ipsWrite) begin
      ips_d = ipsValue;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ip_q <= IP_RST;
    end else begin
      ip_q <= ip_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_q <= SP_RST;
    end else begin
      sp_q <= sp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ips_q <= IPS_RST;
    end else begin
      ips_q <= ips_d;
    end
  end

  // Flags change only by the external write port; exits never touch them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= FLAGS_RST;
    end else if (flagWrite) begin
      flags_q <= flagValue;
    end
  end

  // ---------------------------------------------------------------
  // Status pulses
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      retire_q <= 1'b0;
    end else begin
      retire_q <= execNow;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= takeExit;
    end
  end

  // Unknown codes still retire and step the pointer, so software sees them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unknown_q <= 1'b0;
    end else begin
      unknown_q <= execNow && !decBus.isExit;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign instrReady            = ready_q;
  assign instruction_pointer   = ip_q;
  assign stack_pointer         = sp_q;
  assign interrupt_level_state = ips_q;
  assign statusFlags           = flags_q;
  assign retireStrobe          = retire_q;
  assign exitTaken             = taken_q;
  assign unknownOp             = unknown_q;

endmodule

// file: cie_pkg.sv
// Package for the conditional exit unit: opcode fields, conditions, resets.
package cie_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned IPS_W   = 2;
  localparam int unsigned FLAGS_W = 3;

  // ---------------------------------------------------------------
  // Flag vector positions
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_ZERO  = 1;
  localparam int unsigned FLAG_SIGN  = 2;

  // ---------------------------------------------------------------
  // Opcode field positions
  // ---------------------------------------------------------------
  localparam int unsigned COND_HI  = 15;
  localparam int unsigned COND_LO  = 12;
  localparam int unsigned GRP_HI   = 11;
  localparam int unsigned GRP_LO   = 8;
  localparam int unsigned KIND_HI  = 7;
  localparam int unsigned KIND_LO  = 4;
  localparam int unsigned TAIL_HI  = 3;
  localparam int unsigned TAIL_LO  = 0;

  // ---------------------------------------------------------------
  // Opcode field values
  // ---------------------------------------------------------------
  localparam logic [3:0] GRP_EXIT      = 4'hC;
  localparam logic [3:0] TAIL_EXIT     = 4'hD;
  localparam logic [3:0] KIND_SUB_EXIT = 4'h0;
  localparam logic [3:0] KIND_INT_EXIT = 4'h8;

  localparam logic [3:0] COND_ALWAYS = 4'h8;
  localparam logic [3:0] COND_C      = 4'hA;
  localparam logic [3:0] COND_NC     = 4'hE;
  localparam logic [3:0] COND_Z      = 4'h9;
  localparam logic [3:0] COND_NZ     = 4'hD;
  localparam logic [3:0] COND_S      = 4'hC;

  // ---------------------------------------------------------------
  // Reset and fixed values
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0]  IP_RST      = 16'h0000;
  localparam logic [WORD_W-1:0]  SP_RST      = 16'h0000;
  localparam logic [IPS_W-1:0]   IPS_RST     = 2'h3;
  localparam logic [IPS_W-1:0]   IPS_ACK_OK  = 2'h3;
  localparam logic [FLAGS_W-1:0] FLAGS_RST   = 3'h0;
  localparam logic [WORD_W-1:0]  WORD_ONE    = 16'h0001;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cie_state_e;

endpackage

// file: cie_dec_if.sv
// Interface joining the sequencer to the exit decoder.
`timescale 1ns/10ps
interface cie_dec_if;
  import cie_pkg::*;

  logic [WORD_W-1:0]  opWord;
  logic [FLAGS_W-1:0] flags;
  logic               isExit;
  logic               isIntExit;
  logic               condMet;

  modport core (
    output opWord,
    output flags,
    input  isExit,
    input  isIntExit,
    input  condMet
  );

  modport dec (
    input  opWord,
    input  flags,
    output isExit,
    output isIntExit,
    output condMet
  );
endinterface

// file: cie_exit_decoder.sv
// Combinational decoder for the conditional exit opcodes.
`timescale 1ns/10ps
module cie_exit_decoder
  import cie_pkg::*;
(
  cie_dec_if.dec dec
);

  // ---------------------------------------------------------------
  // Condition test
  // ---------------------------------------------------------------
  function automatic logic condTrue(input logic [3:0] cond, input logic [FLAGS_W-1:0] f);
    logic r;
    r = 1'b0;
    case (cond)
      COND_ALWAYS: r = 1'b1;
      COND_C:      r = f[FLAG_CARRY];
      COND_NC:     r = ~f[FLAG_CARRY];
      COND_Z:      r = f[FLAG_ZERO];
      COND_NZ:     r = ~f[FLAG_ZERO];
      COND_S:      r = f[FLAG_SIGN];
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic condKnown(input logic [3:0] cond);
    logic r;
    r = 1'b0;
    case (cond)
      COND_ALWAYS, COND_C, COND_NC, COND_Z, COND_NZ, COND_S: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Field match
  // ---------------------------------------------------------------
  logic [3:0] cond;
  logic [3:0] kind;
  logic       frame;

  always_comb begin
    cond  = dec.opWord[COND_HI:COND_LO];
    kind  = dec.opWord[KIND_HI:KIND_LO];
    frame = (dec.opWord[GRP_HI:GRP_LO] == GRP_EXIT)
         && (dec.opWord[TAIL_HI:TAIL_LO] == TAIL_EXIT)
         && condKnown(cond);
    dec.isExit    = frame && ((kind == KIND_SUB_EXIT) || (kind == KIND_INT_EXIT));
    dec.isIntExit = frame && (kind == KIND_INT_EXIT);
    dec.condMet   = condTrue(cond, dec.flags);
  end

endmodule

// file: cie_exit_unit_props.sv
// Concurrent checks on the exit unit ports.
`timescale 1ns/10ps
module cie_exit_unit_props
  import cie_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               instrValid,
  input wire logic [WORD_W-1:0]  instrWord,
  input wire logic               instrReady,
  input wire logic [WORD_W-1:0]  stackTopWord,
  input wire logic               flagWrite,
  input wire logic [FLAGS_W-1:0] flagValue,
  input wire logic               ipsWrite,
  input wire logic [IPS_W-1:0]   ipsValue,
  input wire logic [WORD_W-1:0]  instruction_pointer,
  input wire logic [WORD_W-1:0]  stack_pointer,
  input wire logic [IPS_W-1:0]   interrupt_level_state,
  input wire logic [FLAGS_W-1:0] statusFlags,
  input wire logic               retireStrobe,
  input wire logic               exitTaken,
  input wire logic               unknownOp
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_take_retire: assert property (
    instrValid && instrReady |=> !instrReady ##1 retireStrobe)
    else $error("no retire two cycles after take");
  a_taken_ip: assert property (
    retireStrobe && exitTaken |-> instruction_pointer == $past(stackTopWord))
    else $error("taken exit ip not stack top");
  a_fall_ip: assert property (
    retireStrobe && !exitTaken
    |-> instruction_pointer == 16'($past(instruction_pointer) + 1))
    else $error("fall through ip not plus one");
  a_sp_pop: assert property (
    retireStrobe && exitTaken |-> stack_pointer == 16'($past(stack_pointer) - 1))
    else $error("taken exit sp not decremented");
  a_ips_set: assert property (
    retireStrobe && exitTaken && $past(instrWord[7:4], 2) == KIND_INT_EXIT
    |-> interrupt_level_state == IPS_ACK_OK)
    else $error("ips not 11b after interrupt exit");
  a_fall_ips: assert property (
    retireStrobe && !exitTaken && !$past(ipsWrite) |-> $stable(interrupt_level_state))
    else $error("ips changed on fall through");
  a_flags_kept: assert property (
    !$past(flagWrite) |-> $stable(statusFlags))
    else $error("flags changed without write");
  a_carry_cond: assert property (
    retireStrobe && $past(instrWord, 2) == 16'hAC8D
    |-> exitTaken == $past(statusFlags[FLAG_CARRY]))
    else $error("carry exit decision wrong");
  a_sign_sub: assert property (
    retireStrobe && $past(instrWord, 2) == 16'hCC0D
    |-> exitTaken == $past(statusFlags[FLAG_SIGN]))
    else $error("sign subroutine exit decision wrong");
endmodule

// file: test_cie_exit_unit.sv
// Self-checking bench for the exit unit.
`timescale 1ns/10ps
module test_cie_exit_unit
  import cie_pkg::*;
;
  logic               clk, sys_rst, instrValid, flagWrite, ipsWrite;
  logic               instrReady, retireStrobe, exitTaken, unknownOp;
  logic [WORD_W-1:0]  instrWord, stackTopWord, instruction_pointer, stack_pointer;
  logic [FLAGS_W-1:0] flagValue, statusFlags;
  logic [IPS_W-1:0]   ipsValue, interrupt_level_state;
  int                 n_fail = 0, checks = 0;
  logic [31:0]        rnd = 32'h527A;
  logic [15:0]        mIp = 16'h0000, mSp = 16'h0000;
  logic [1:0]         mIps = 2'h3;
  logic [3:0]         conds [6] = '{COND_ALWAYS, COND_C, COND_NC, COND_Z, COND_NZ, COND_S};
  logic [15:0]        odd [5] = '{16'h8C1D, 16'h8B8D, 16'h8C8C, 16'hFC8D, 16'h0C0D};

  cie_exit_unit u_cie_exit_unit (.clk, .sys_rst, .instrValid, .instrWord, .instrReady,
    .stackTopWord, .flagWrite, .flagValue, .ipsWrite, .ipsValue, .instruction_pointer,
    .stack_pointer, .interrupt_level_state, .statusFlags, .retireStrobe, .exitTaken, .unknownOp);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset for n cycles, check every reset value except exitTaken and unknownOp, resync the model
  task automatic reset_for(int n);
    sys_rst = 1'h1;
    repeat (n) @(negedge clk);
    chk("ip rst", IP_RST, instruction_pointer);
    chk("sp rst", SP_RST, stack_pointer);
    chk("ips rst", IPS_RST, interrupt_level_state);
    chk("flags rst", FLAGS_RST, statusFlags);
    chk("ready rst", 1, instrReady);
    chk("retire rst", 0, retireStrobe);
    mIp = IP_RST;
    mSp = SP_RST;
    mIps = IPS_RST;
    sys_rst = 1'h0;
  endtask

  // ---------------------------------------------------------------
  // One opcode: flag setup cycle, take, exec, compare
  // ---------------------------------------------------------------
  task automatic run(logic [15:0] op, logic [2:0] f);
    logic known, taken;
    logic [15:0] top;
    rnd = lfsr(rnd);
    flagWrite = 1'h1;
    flagValue = f;
    ipsWrite = rnd[3];
    ipsValue = rnd[5:4];
    if (rnd[3]) mIps = rnd[5:4];
    @(negedge clk);
    chk("ready", 1, instrReady);
    chk("retire idle", 0, retireStrobe);
    chk("taken idle", 0, exitTaken);
    chk("unknown idle", 0, unknownOp);
    flagWrite = 1'h0;
    ipsWrite = 1'h0;
    instrValid = 1'h1;
    instrWord = op;
    @(negedge clk);
    rnd = lfsr(rnd);
    chk("busy", 0, instrReady);
    // Offer stays up while busy: must be ignored
    instrWord = rnd[31:16];
    top = rnd[15:0];
    stackTopWord = top;
    ipsWrite = rnd[16];
    ipsValue = rnd[18:17];
    known = op[11:8] == GRP_EXIT && op[3:0] == TAIL_EXIT
      && op[7:4] inside {KIND_SUB_EXIT, KIND_INT_EXIT}
      && op[15:12] inside {COND_ALWAYS, COND_C, COND_NC, COND_Z, COND_NZ, COND_S};
    case (op[15:12])
      COND_ALWAYS: taken = known;
      COND_C:      taken = known && f[FLAG_CARRY];
      COND_NC:     taken = known && !f[FLAG_CARRY];
      COND_Z:      taken = known && f[FLAG_ZERO];
      COND_NZ:     taken = known && !f[FLAG_ZERO];
      COND_S:      taken = known && f[FLAG_SIGN];
      default:     taken = 1'h0;
    endcase
    mIp = taken ? top : mIp + 16'h0001;
    if (taken) mSp = mSp - 16'h0001;
    if (taken && op[7:4] == KIND_INT_EXIT) mIps = 2'h3;
    else if (rnd[16]) mIps = rnd[18:17];
    @(negedge clk);
    instrValid = 1'h0;
    stackTopWord = ~top;
    chk("retire", 1, retireStrobe);
    chk("taken", taken, exitTaken);
    chk("unknown", !known, unknownOp);
    chk("ip", mIp, instruction_pointer);
    chk("sp", mSp, stack_pointer);
    chk("ips", mIps, interrupt_level_state);
    chk("flags", f, statusFlags);
  endtask

  initial begin
    instrValid = 1'h0;
    instrWord = 16'h0000;
    stackTopWord = 16'h0000;
    flagWrite = 1'h0;
    flagValue = 3'h0;
    ipsWrite = 1'h0;
    ipsValue = 2'h0;
    reset_for(8);
    // Every condition, both exit kinds, every flag pattern
    for (int c = 0; c < 6; c++) begin
      for (int k = 0; k < 16; k++) begin
        run({conds[c], GRP_EXIT, k[3] ? KIND_INT_EXIT : KIND_SUB_EXIT, TAIL_EXIT}, k[2:0]);
      end
    end
    foreach (odd[i]) run(odd[i], 3'h7);
    // Mid-run reset, then more traffic from the reset state
    reset_for(2);
    for (int i = 0; i < 20; i++) begin
      rnd = lfsr(rnd);
      run(rnd[30:15], rnd[2:0]);
    end
    final_report();
  end
endmodule

bind cie_exit_unit cie_exit_unit_props u_props (.clk, .sys_rst, .instrValid, .instrWord,
  .instrReady, .stackTopWord, .flagWrite, .flagValue, .ipsWrite, .ipsValue,
  .instruction_pointer, .stack_pointer, .interrupt_level_state, .statusFlags,
  .retireStrobe, .exitTaken, .unknownOp);
